/* File: hw/rfm_pkg.sv */
// Shared constants and types for the radio modem mode controller.
// Assumes a 200 MHz system clock; all timers run from a 1 ms tick.
package rfm_pkg;

    // Clock and time base
    localparam int CLK_PERIOD_PS = 5000;          // 200 MHz system clock
    localparam int MS_IN_PS      = 1_000_000_000; // One millisecond
    localparam int MS_CYCLES     = MS_IN_PS / CLK_PERIOD_PS;

    // Sleep and initializer timing, in milliseconds
    localparam int LISTEN_MS     = 100;  // Listen window after a cyclic wake
    localparam int SLEEP_BASE_MS = 500;  // Shortest cyclic sleep interval
    localparam int LH_UNIT_MS    = 100;  // Unit of the wake-up initializer timer
    localparam int INIT_DEF_MS   = 35;   // Plain initializer when the timer is zero

    // Buffer and flow control
    localparam int BUF_DEPTH_DEF = 1024; // Serial input buffer depth
    localparam int PKT_W_DEF     = 8;    // Width of packet size and threshold
    localparam int FC_OFF_FREE   = 65;   // Free bytes left when clear-to-send drops
    localparam int FC_ON_MORE    = 34;   // Bytes to free before it returns

    // Packet layout
    localparam int HDR_LEN = 5;          // Channel, tag (2), destination (2)
    localparam int CRC_LEN = 2;

    // CRC-16, MSB first, no final inversion
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h1021;

    // Sleep mode settings
    localparam logic [3:0] SM_OFF     = 4'h0;
    localparam logic [3:0] SM_PIN     = 4'h1;
    localparam logic [3:0] SM_CYC_MIN = 4'h3;
    localparam logic [3:0] SM_CYC_MAX = 4'h8;

    // Operating modes, one-hot
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_INIT  = 7'h02,
        ST_HDR   = 7'h04,
        ST_PAY   = 7'h08,
        ST_CRC   = 7'h10,
        ST_RX    = 7'h20,
        ST_SLEEP = 7'h40
    } rfm_state_e;

endpackage : rfm_pkg

/* File: hw/rfm_crc16.sv */
// Byte-wide CRC-16 accumulator used on both the transmit and receive paths.
// Assumes bytes arrive on single-cycle enables from logic on the same clock.
`timescale 1ns/1ps
module rfm_crc16 (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        clr,   // Restart; with en the byte is the first one
    input  wire logic        en,    // Fold data into the checksum
    input  wire logic [7:0]  data,
    output logic      [15:0] crc
);
    import rfm_pkg::*;

    logic [15:0] crc_q;   // Running checksum
    logic [15:0] crc_d;

    // One byte, MSB first
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {d, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ({r[14:0], 1'b0} ^ CRC_POLY) : {r[14:0], 1'b0};
        end
        return r;
    endfunction : crc_step

    // Next checksum; clear wins the base so a new packet starts clean
    always_comb begin
        crc_d = crc_q;
        if (en) begin
            crc_d = crc_step(clr ? CRC_INIT : crc_q, data);
        end else if (clr) begin
            crc_d = CRC_INIT;
        end
    end

    // Register
    always_ff @(posedge clk) begin
        if (reset) begin
            crc_q <= CRC_INIT;
        end else begin
            crc_q <= crc_d;
        end
    end

    assign crc = crc_q;

endmodule : rfm_crc16

/* File: hw/rfm_mode_ctrl.sv */
// Operating-mode controller of a serial-to-radio modem: input buffer,
// packet framing, receive filtering and pin or cyclic sleep.
// Assumes a UART and a radio byte engine on the same clock; only the
// sleep pin comes from outside and is synchronised here.
// Function
// - Transmit when pending bytes reach threshold.
// - Threshold 1 to packet size; zero disables.
// - Quiet-line timeout triggers transmit; zero disables.
// - Never start transmit during reception.
// - Send initializer; keep buffering serial bytes.
// - Split data into packets until buffer empty.
// - At packet end, continue if bytes remain.
// - Initializer only before first streamed packet.
// - Wake-up initializer longer than remote sleep.
// - Drop packets with wrong channel, tag, address.
// - Append 16-bit CRC to every packet.
// - Forward valid-CRC packets, drop invalid ones.
// - Idle to receive on RF; back on end/error.
// - Serial data held during receive, sent later.
// - Sleep needs nonzero mode plus timeout or pin.
// - Mode 1: sleep pin high sleeps, low wakes.
// - Pin sleep: clear-to-send high, power low.
// - Finish transfer in progress before pin sleep.
// - Cyclic sleep interval, then 100 ms listen.
// - Cyclic sleep holds outputs; listen transmits input.
// - Pin wake forces idle until inactivity timeout.
// - Sleep interval shorter than wake-up initializer.
// - Clear-to-send off at 65 free, on after 34.
`timescale 1ns/1ps
module rfm_mode_ctrl #(
    parameter int BUF_DEPTH = rfm_pkg::BUF_DEPTH_DEF, // Input buffer depth, power of two
    parameter int PKT_W     = rfm_pkg::PKT_W_DEF,     // Width of packet size and threshold
    parameter int MS_CYCLES = rfm_pkg::MS_CYCLES      // Clock cycles per millisecond tick
) (
    input  wire logic                CLK_SYS,
    input  wire logic                RESET,
    input  wire logic                DIN_VALID,
    input  wire logic [7:0]          DIN_DATA,
    input  wire logic [PKT_W-1:0]    PACKET_BYTE_THRESHOLD,
    input  wire logic [7:0]          PACKET_IDLE_TIMEOUT,
    input  wire logic [PKT_W-1:0]    RF_PACKET_SIZE,
    input  wire logic [7:0]          HOP_CHANNEL_SELECT,
    input  wire logic [15:0]         VENDOR_NETWORK_TAG,
    input  wire logic [15:0]         DESTINATION_ADDR,
    input  wire logic [3:0]          SLEEP_MODE_SELECT,
    input  wire logic [15:0]         TIME_BEFORE_SLEEP,
    input  wire logic                PIN_WAKEUP_ENABLE,
    input  wire logic [7:0]          WAKEUP_INITIALIZER_TIMER,
    input  wire logic                SLEEP_PIN,
    input  wire logic                TX_READY,
    output logic                     TX_VALID,
    output logic [7:0]               TX_DATA,
    output logic                     TX_INIT,
    input  wire logic                RX_CARRIER,
    input  wire logic                RX_VALID,
    input  wire logic [7:0]          RX_DATA,
    input  wire logic                RX_LAST,
    input  wire logic                RX_ERROR,
    output logic                     DOUT_VALID,
    output logic [7:0]               DOUT_DATA,
    output logic                     DOUT_COMMIT,
    output logic                     DOUT_DISCARD,
    output logic                     CTS_N,
    output logic                     PWR,
    output rfm_pkg::rfm_state_e      MODE
);
    import rfm_pkg::*;

    localparam int AW = $clog2(BUF_DEPTH);
    localparam int CW = AW + 1;
    localparam int DW = $clog2(MS_CYCLES);
    localparam logic [CW-1:0] FULL_LVL   = CW'(BUF_DEPTH);
    localparam logic [CW-1:0] FC_OFF_LVL = CW'(BUF_DEPTH - FC_OFF_FREE);
    localparam logic [CW-1:0] FC_ON_LVL  = CW'(BUF_DEPTH - FC_OFF_FREE - FC_ON_MORE);

    // Refuse depths the flow-control levels cannot serve
    if (BUF_DEPTH < 128 || (1 << AW) != BUF_DEPTH || PKT_W > CW || MS_CYCLES < 2) begin : g_chk
        $error("rfm_mode_ctrl: unsupported parameter values");
    end

    // Sleep pin synchroniser; only the second stage is read
    logic sleep_s1_q, sleep_s2_q;
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            sleep_s1_q <= 1'b0;
            sleep_s2_q <= 1'b0;
        end else begin
            sleep_s1_q <= SLEEP_PIN;
            sleep_s2_q <= sleep_s1_q;
        end
    end

    // ---------------- Serial input buffer ----------------
    logic [7:0]    mem_q [BUF_DEPTH];  // Pending serial bytes
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [CW-1:0] cnt_q, cnt_d;       // Bytes waiting for transmission
    logic          push, pop;

    // Bytes keep landing in every mode; a full buffer drops the byte
    always_comb begin
        push  = DIN_VALID && (cnt_q != FULL_LVL);
        wr_d  = push ? wr_q + 1'b1 : wr_q;
        rd_d  = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + CW'(push) - CW'(pop);
    end

    // Storage has no reset, only pointers and count do
    always_ff @(posedge CLK_SYS) begin
        if (push) begin
            mem_q[wr_q] <= DIN_DATA;
        end
        if (RESET) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // ---------------- Millisecond timers ----------------
    rfm_state_e    state_q, state_d;
    logic [DW-1:0] div_q, div_d;      // Tick prescaler
    logic [15:0]   quiet_q, quiet_d;  // ms since last serial byte
    logic [15:0]   inact_q, inact_d;  // ms since last activity
    logic          tick, active;

    // Saturating counters so long quiet spells never wrap back to zero
    always_comb begin
        tick    = (div_q == DW'(MS_CYCLES - 1));
        div_d   = tick ? '0 : div_q + 1'b1;
        active  = push || RX_CARRIER || (state_q != ST_IDLE);
        quiet_d = quiet_q;
        inact_d = inact_q;
        if (push) begin
            quiet_d = '0;
        end else if (tick && quiet_q != 16'hFFFF) begin
            quiet_d = quiet_q + 1'b1;
        end
        if (active) begin
            inact_d = '0;
        end else if (tick && inact_q != 16'hFFFF) begin
            inact_d = inact_q + 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            div_q   <= '0;
            quiet_q <= '0;
            inact_q <= '0;
        end else begin
            div_q   <= div_d;
            quiet_q <= quiet_d;
            inact_q <= inact_d;
        end
    end

    // ---------------- Mode decisions ----------------
    logic [PKT_W-1:0] rb_eff;
    logic             rb_hit, ro_hit, tx_go, st_done, is_pin, is_cyc, pin_hi;
    logic [15:0]      init_ms, cyc_ms;

    always_comb begin
        rb_eff  = (PACKET_BYTE_THRESHOLD > RF_PACKET_SIZE) ? RF_PACKET_SIZE
                                                           : PACKET_BYTE_THRESHOLD;
        rb_hit  = (rb_eff != '0) && (cnt_q >= CW'(rb_eff));
        ro_hit  = (PACKET_IDLE_TIMEOUT != 8'h00) && (cnt_q != '0)
                  && (quiet_q >= 16'(PACKET_IDLE_TIMEOUT));
        tx_go   = rb_hit || ro_hit;
        st_done = (TIME_BEFORE_SLEEP != 16'h0000) && (inact_q >= TIME_BEFORE_SLEEP);
        is_pin  = (SLEEP_MODE_SELECT == SM_PIN);
        is_cyc  = (SLEEP_MODE_SELECT >= SM_CYC_MIN) && (SLEEP_MODE_SELECT <= SM_CYC_MAX);
        pin_hi  = sleep_s2_q;
        // Longer initializer when the wake-up timer is set, to rouse sleepers
        init_ms = (WAKEUP_INITIALIZER_TIMER != 8'h00)
                  ? 16'(WAKEUP_INITIALIZER_TIMER) * 16'(LH_UNIT_MS)
                  : 16'(INIT_DEF_MS);
        cyc_ms  = 16'(SLEEP_BASE_MS) << (SLEEP_MODE_SELECT - SM_CYC_MIN);
    end

    // ---------------- CRC engines ----------------
    logic [7:0]  tx_data_q, tx_data_d;
    logic        tx_valid_q, tx_valid_d, tx_acc, tx_clr, tx_en, rx_clr, rx_en;
    logic [15:0] tx_crc, rx_crc;

    rfm_crc16 u_tx_crc (
        .clk   (CLK_SYS),
        .reset (RESET),
        .clr   (tx_clr),
        .en    (tx_en),
        .data  (tx_data_q),
        .crc   (tx_crc)
    );

    rfm_crc16 u_rx_crc (
        .clk   (CLK_SYS),
        .reset (RESET),
        .clr   (rx_clr),
        .en    (rx_en),
        .data  (RX_DATA),
        .crc   (rx_crc)
    );

    // Header byte i, shared by framing and filtering
    function automatic logic [7:0] hdr_byte(input logic [2:0] i);
        case (i)
            3'h0:    hdr_byte = HOP_CHANNEL_SELECT;
            3'h1:    hdr_byte = VENDOR_NETWORK_TAG[15:8];
            3'h2:    hdr_byte = VENDOR_NETWORK_TAG[7:0];
            3'h3:    hdr_byte = DESTINATION_ADDR[15:8];
            default: hdr_byte = DESTINATION_ADDR[7:0];
        endcase
    endfunction : hdr_byte

    // ---------------- Main state machine ----------------
    logic [15:0]      timer_q, timer_d;     // ms in the current phase
    logic             listen_q, listen_d;   // Awake for the listen window
    logic [2:0]       hidx_q, hidx_d;       // Header byte index
    logic             cidx_q, cidx_d;       // CRC byte index
    logic [PKT_W-1:0] left_q, left_d;       // Payload bytes still to send
    logic [2:0]       ridx_q, ridx_d;       // Received byte index, saturating
    logic             drop_q, drop_d;       // Header mismatch seen
    logic [7:0]       lag0_q, lag0_d, lag1_q, lag1_d; // Hides the trailing CRC
    logic [1:0]       lagn_q, lagn_d;
    logic             chk_q, chk_d, bad_q, bad_d;     // Verdict due next cycle
    logic             dv_q, dv_d, cm_q, cm_d, dc_q, dc_d, cts_q, cts_d;
    logic [7:0]       dd_q, dd_d;

    always_comb begin
        state_d = state_q;
        timer_d = (tick && timer_q != 16'hFFFF) ? timer_q + 1'b1 : timer_q;
        listen_d = listen_q;
        hidx_d = hidx_q;  cidx_d = cidx_q;  left_d = left_q;
        ridx_d = ridx_q;  drop_d = drop_q;
        lag0_d = lag0_q;  lag1_d = lag1_q;  lagn_d = lagn_q;
        chk_d = 1'b0;     bad_d = bad_q;
        dv_d = 1'b0;      dd_d = dd_q;  cm_d = 1'b0;  dc_d = 1'b0;
        tx_valid_d = tx_valid_q;
        tx_data_d  = tx_data_q;
        tx_acc = tx_valid_q && TX_READY;
        tx_clr = 1'b0;
        tx_en  = 1'b0;
        pop    = 1'b0;
        rx_en  = (state_q == ST_RX) && RX_VALID;
        rx_clr = rx_en && (ridx_q == 3'h0);
        case (state_q)
            ST_IDLE: begin
                if (RX_CARRIER) begin
                    state_d = ST_RX;
                    listen_d = 1'b0;
                    ridx_d = '0;  drop_d = 1'b0;  lagn_d = '0;
                end else if (is_pin && pin_hi) begin
                    state_d = ST_SLEEP;
                end else if (listen_q && timer_q >= 16'(LISTEN_MS)) begin
                    state_d = ST_SLEEP;
                end else if (tx_go) begin
                    state_d = ST_INIT;
                    listen_d = 1'b0;
                end else if ((is_pin || is_cyc) && st_done && !listen_q) begin
                    state_d = ST_SLEEP;
                end
                if (state_d != ST_IDLE) begin
                    timer_d = '0;
                end
            end
            ST_INIT: begin
                // Serial bytes keep arriving while the initializer runs
                if (timer_q >= init_ms) begin
                    state_d = ST_HDR;
                    hidx_d = '0;
                end
            end
            ST_HDR: begin
                if (tx_acc) begin
                    tx_valid_d = 1'b0;
                    tx_en  = 1'b1;
                    tx_clr = (hidx_q == 3'h0);
                    hidx_d = hidx_q + 1'b1;
                    if (hidx_q == 3'(HDR_LEN - 1)) begin
                        // Payload is whatever is pending, capped at packet size
                        state_d = ST_PAY;
                        left_d = (cnt_q > CW'(RF_PACKET_SIZE)) ? RF_PACKET_SIZE
                                                              : cnt_q[PKT_W-1:0];
                    end
                end else if (!tx_valid_q) begin
                    tx_valid_d = 1'b1;
                    tx_data_d = hdr_byte(hidx_q);
                end
            end
            ST_PAY: begin
                if (left_q == '0) begin
                    state_d = ST_CRC;
                    cidx_d = 1'b0;
                end else if (tx_acc) begin
                    tx_valid_d = 1'b0;
                    tx_en = 1'b1;
                    pop = 1'b1;
                    left_d = left_q - 1'b1;
                end else if (!tx_valid_q) begin
                    tx_valid_d = 1'b1;
                    tx_data_d = mem_q[rd_q];
                end
            end
            ST_CRC: begin
                if (tx_acc) begin
                    tx_valid_d = 1'b0;
                    cidx_d = 1'b1;
                    if (cidx_q) begin
                        // Streamed follow-on packets skip the initializer
                        state_d = (cnt_q != '0) ? ST_HDR : ST_IDLE;
                        hidx_d = '0;
                        timer_d = '0;
                    end
                end else if (!tx_valid_q) begin
                    tx_valid_d = 1'b1;
                    tx_data_d = cidx_q ? tx_crc[7:0] : tx_crc[15:8];
                end
            end
            ST_RX: begin
                if (RX_ERROR || !RX_CARRIER) begin
                    state_d = ST_IDLE;
                    timer_d = '0;
                    dc_d = (ridx_q != 3'h0);
                end else if (RX_VALID) begin
                    ridx_d = (ridx_q == 3'h7) ? ridx_q : ridx_q + 1'b1;
                    if (ridx_q < 3'(HDR_LEN)) begin
                        if (RX_DATA != hdr_byte(ridx_q)) begin
                            drop_d = 1'b1;
                        end
                    end else if (lagn_q == 2'h2) begin
                        dv_d = !drop_q;
                        dd_d = lag0_q;
                        lag0_d = lag1_q;
                        lag1_d = RX_DATA;
                    end else begin
                        if (lagn_q == 2'h0) begin
                            lag0_d = RX_DATA;
                        end else begin
                            lag1_d = RX_DATA;
                        end
                        lagn_d = lagn_q + 1'b1;
                    end
                    if (RX_LAST) begin
                        chk_d = 1'b1;
                        bad_d = drop_d || (ridx_q < 3'(HDR_LEN + CRC_LEN - 1));
                        ridx_d = '0;  drop_d = 1'b0;  lagn_d = '0;
                    end
                end
            end
            ST_SLEEP: begin
                if (is_pin) begin
                    if (!pin_hi) begin
                        state_d = ST_IDLE;
                    end
                end else if (is_cyc) begin
                    if (PIN_WAKEUP_ENABLE && !pin_hi) begin
                        state_d = ST_IDLE;
                        listen_d = 1'b0;
                    end else if (timer_q >= cyc_ms) begin
                        state_d = ST_IDLE;
                        listen_d = 1'b1;
                    end
                end else begin
                    state_d = ST_IDLE;
                end
                if (state_d != ST_SLEEP) begin
                    timer_d = '0;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // Checksum over header, payload and CRC leaves zero when intact
        if (chk_q) begin
            cm_d = !bad_q && (rx_crc == 16'h0000);
            dc_d = !cm_d;
        end
        // Sleep forces clear-to-send off; otherwise hysteresis on fill level
        if (state_d == ST_SLEEP) begin
            cts_d = 1'b1;
        end else if (cnt_d >= FC_OFF_LVL) begin
            cts_d = 1'b1;
        end else if (cnt_d <= FC_ON_LVL) begin
            cts_d = 1'b0;
        end else begin
            cts_d = cts_q;
        end
    end

    // Register all mode state
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            state_q <= ST_IDLE;  timer_q <= '0;  listen_q <= 1'b0;
            hidx_q <= '0;  cidx_q <= 1'b0;  left_q <= '0;
            ridx_q <= '0;  drop_q <= 1'b0;  lagn_q <= '0;
            lag0_q <= '0;  lag1_q <= '0;  chk_q <= 1'b0;  bad_q <= 1'b0;
            tx_valid_q <= 1'b0;  tx_data_q <= '0;
            dv_q <= 1'b0;  dd_q <= '0;  cm_q <= 1'b0;  dc_q <= 1'b0;
            cts_q <= 1'b0;  TX_INIT <= 1'b0;  PWR <= 1'b1;
        end else begin
            state_q <= state_d;  timer_q <= timer_d;  listen_q <= listen_d;
            hidx_q <= hidx_d;  cidx_q <= cidx_d;  left_q <= left_d;
            ridx_q <= ridx_d;  drop_q <= drop_d;  lagn_q <= lagn_d;
            lag0_q <= lag0_d;  lag1_q <= lag1_d;  chk_q <= chk_d;  bad_q <= bad_d;
            tx_valid_q <= tx_valid_d;  tx_data_q <= tx_data_d;
            dv_q <= dv_d;  dd_q <= dd_d;  cm_q <= cm_d;  dc_q <= dc_d;
            cts_q <= cts_d;
            TX_INIT <= (state_d == ST_INIT);
            PWR <= (state_d != ST_SLEEP);
        end
    end

    assign TX_VALID     = tx_valid_q;
    assign TX_DATA      = tx_data_q;
    assign DOUT_VALID   = dv_q;
    assign DOUT_DATA    = dd_q;
    assign DOUT_COMMIT  = cm_q;
    assign DOUT_DISCARD = dc_q;
    assign CTS_N        = cts_q;
    assign MODE         = state_q;

endmodule : rfm_mode_ctrl

/* File: tb/rfm_mode_chk.sv */
// Port-level checker for the modem mode controller, bound to every instance.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module rfm_mode_chk (
    input wire logic                CLK_SYS,
    input wire logic                RESET,
    input wire logic [3:0]          SLEEP_MODE_SELECT,
    input wire logic                SLEEP_PIN,
    input wire logic                TX_READY,
    input wire logic                TX_VALID,
    input wire logic [7:0]          TX_DATA,
    input wire logic                RX_CARRIER,
    input wire logic                RX_ERROR,
    input wire logic                DOUT_COMMIT,
    input wire logic                DOUT_DISCARD,
    input wire logic                CTS_N,
    input wire logic                PWR,
    input wire rfm_pkg::rfm_state_e MODE
);
    import rfm_pkg::*;
    // All checks share the system clock and drop out while reset is high
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    sleep_outs_a: assert property (MODE == ST_SLEEP |-> CTS_N && !PWR)
        else $error("handshake outputs active while asleep");
    rx_enter_a: assert property (MODE == ST_IDLE && RX_CARRIER |=> MODE == ST_RX)
        else $error("carrier in idle did not start reception");
    no_tx_rx_a: assert property (MODE == ST_RX |=> MODE != ST_INIT)
        else $error("transmit started straight out of reception");
    stream_a: assert property (MODE == ST_CRC |=> MODE != ST_INIT)
        else $error("initializer repeated between streamed packets");
    tx_hold_a: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
        else $error("transmit byte changed before it was taken");
    rx_error_a: assert property (MODE == ST_RX && RX_ERROR |-> ##[1:2] DOUT_DISCARD)
        else $error("receive error did not discard");
    verdict_a: assert property (DOUT_COMMIT |-> !DOUT_DISCARD ##1 !DOUT_COMMIT)
        else $error("commit not a lone pulse");
    pin_wake_a: assert property (MODE == ST_SLEEP && SLEEP_MODE_SELECT == SM_PIN && !SLEEP_PIN
        |-> ##[1:5] MODE != ST_SLEEP)
        else $error("low sleep pin did not wake");
    off_awake_a: assert property (SLEEP_MODE_SELECT == SM_OFF && MODE != ST_SLEEP
        |=> MODE != ST_SLEEP)
        else $error("slept with sleep disabled");
endmodule : rfm_mode_chk
bind rfm_mode_ctrl rfm_mode_chk chk (.*);

/* File: tb/rfm_radio_sink.sv */
// Radio byte engine stand-in: takes transmit bytes, stalling when slow.
// Assumes the modem clock; ready moves 1 ns after each rising edge.
`timescale 1ns/1ps
module rfm_radio_sink (
    input  wire logic clk,
    input  wire logic slow,  // Take a byte only every other cycle
    output logic      ready = 1'b0
);
    // Toggling ready tests that the modem holds its byte through stalls
    always @(posedge clk) ready <= #1 slow ? ~ready : 1'b1;
endmodule : rfm_radio_sink

/* File: tb/tb_rfm_mode_ctrl.sv */
// Self-checking bench for the modem mode controller with a radio sink.
// Assumes 10-cycle millisecond ticks so timeouts stay short.
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; $display("mismatch %0t: got %0h want %0h", $time, a, e); end end
module tb_rfm_mode_ctrl;
    import rfm_pkg::*;
    logic CLK_SYS = 0, RESET = 1, DIN_VALID = 0, PIN_WAKEUP_ENABLE = 0, SLEEP_PIN = 0, slow = 0;
    logic RX_CARRIER = 0, RX_VALID = 0, RX_LAST = 0, RX_ERROR = 0, init_q = 0;
    logic [7:0] DIN_DATA = 0, PACKET_BYTE_THRESHOLD = 4, PACKET_IDLE_TIMEOUT = 0, RX_DATA = 0;
    logic [7:0] RF_PACKET_SIZE = 4, HOP_CHANNEL_SELECT = 8'h05, WAKEUP_INITIALIZER_TIMER = 0;
    logic [15:0] VENDOR_NETWORK_TAG = 16'h3332, DESTINATION_ADDR = 16'h00A1, TIME_BEFORE_SLEEP = 0;
    logic [3:0] SLEEP_MODE_SELECT = 0;
    logic TX_READY, TX_VALID, TX_INIT, DOUT_VALID, DOUT_COMMIT, DOUT_DISCARD, CTS_N, PWR;
    logic [7:0] TX_DATA, DOUT_DATA, txq[$], exp[$], outq[$], f[$];
    rfm_state_e MODE;
    int fails = 0, tests_run = 0, inits = 0, commits = 0, drops = 0;
    rfm_mode_ctrl #(.BUF_DEPTH(128), .MS_CYCLES(10)) dut (.*);
    rfm_radio_sink radio (.clk(CLK_SYS), .slow(slow), .ready(TX_READY));
    initial forever #2.5 CLK_SYS = ~CLK_SYS;
    // Collect what leaves the block on both sides
    always @(posedge CLK_SYS) begin
        if (TX_VALID && TX_READY) txq.push_back(TX_DATA);
        if (DOUT_VALID) outq.push_back(DOUT_DATA);
        inits += TX_INIT && !init_q;
        init_q = TX_INIT;
        commits += DOUT_COMMIT;
        drops += DOUT_DISCARD;
    end
    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c = CRC_INIT;
        foreach (b[i]) begin
            c ^= {b[i], 8'h00};
            repeat (8) c = c[15] ? (c << 1) ^ CRC_POLY : c << 1;
        end
        return c;
    endfunction : crc16
    // Header, payload and checksum of one packet into f
    task automatic mk(input logic [7:0] p[$], input logic [15:0] d);
        logic [15:0] c;
        f = {HOP_CHANNEL_SELECT, VENDOR_NETWORK_TAG[15:8], VENDOR_NETWORK_TAG[7:0], d[15:8], d[7:0]};
        f = {f, p};
        c = crc16(f);
        f = {f, c[15:8], c[7:0]};
    endtask : mk
    task automatic ser(input int n, input logic [7:0] b);
        for (int i = 0; i < n; i++) begin
            @(posedge CLK_SYS) #1 DIN_VALID = 1;
            DIN_DATA = 8'(b + i);
        end
        @(posedge CLK_SYS) #1 DIN_VALID = 0;
    endtask : ser
    // Radio bytes; an error case stops at the fourth byte
    task automatic rx(input bit err);
        int n;
        n = err ? 4 : f.size();
        for (int i = 0; i < n; i++) begin
            @(posedge CLK_SYS) #1 RX_VALID = 1;
            RX_DATA = f[i];
            RX_LAST = !err && i == n - 1;
            RX_ERROR = err && i == n - 1;
        end
        @(posedge CLK_SYS) #1 {RX_VALID, RX_LAST, RX_ERROR} = 3'h0;
        repeat (4) @(posedge CLK_SYS);
    endtask : rx
    task automatic chk_tx;
        repeat (3000) if (txq.size() < exp.size()) @(posedge CLK_SYS);
        `CHK(txq.size(), exp.size())
        foreach (exp[i]) `CHK(txq[i], exp[i])
        txq = {};
        #1 exp = {};
    endtask : chk_tx
    task conclude;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    initial begin
        repeat (20000) @(posedge CLK_SYS);
        fails++;
        conclude();
    end
    initial begin
        repeat (16) @(posedge CLK_SYS);
        #1 RESET = 0;
        slow = 1;
        ser(6, 8'h10);
        mk({8'h10, 8'h11, 8'h12, 8'h13}, DESTINATION_ADDR);
        exp = f;
        mk({8'h14, 8'h15}, DESTINATION_ADDR);
        exp = {exp, f};
        chk_tx();
        {PACKET_BYTE_THRESHOLD, PACKET_IDLE_TIMEOUT, RF_PACKET_SIZE} = {8'h00, 8'h03, 8'h02};
        WAKEUP_INITIALIZER_TIMER = 1;
        ser(1, 8'h20);
        mk({8'h20}, DESTINATION_ADDR);
        exp = f;
        chk_tx();
        RX_CARRIER = 1;
        repeat (3) @(posedge CLK_SYS);
        ser(1, 8'h30);
        repeat (40) @(posedge CLK_SYS);
        for (int k = 0; k < 4; k++) begin
            mk({8'(8'h40 + k), 8'h50}, k == 1 ? DESTINATION_ADDR ^ 16'h0001 : DESTINATION_ADDR);
            if (k == 2) f[f.size() - 1] ^= 8'h01;
            rx(k == 3);
        end
        #1 RX_CARRIER = 0;
        `CHK(commits, 1)
        `CHK(drops >= 3, 1'b1)
        txq = outq;
        exp = {8'h40, 8'h50, 8'h42, 8'h50};
        chk_tx();
        mk({8'h30}, DESTINATION_ADDR);
        exp = f;
        chk_tx();
        `CHK(inits, 3)
        SLEEP_PIN = 1;
        repeat (8) @(posedge CLK_SYS);
        `CHK(MODE, ST_IDLE)
        #1 SLEEP_MODE_SELECT = SM_PIN;
        repeat (8) @(posedge CLK_SYS);
        `CHK({MODE, CTS_N, PWR}, {ST_SLEEP, 2'b10})
        #1 SLEEP_PIN = 0;
        repeat (8) @(posedge CLK_SYS);
        `CHK({MODE, PWR}, {ST_IDLE, 1'b1})
        ser(63, 8'h00);
        `CHK(CTS_N, 1'b1)
        conclude();
    end
endmodule : tb_rfm_mode_ctrl
